// file: dv/arc_top_chk.sv
// Port-level assertions for the converter result and clock block
`timescale 1ns/1ps
module arc_chk (
   // Clock, reset, enable
   input wire clk_sys,
   input wire rst,
   input wire ce,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Converter and interrupt
   input wire conv_done,
   input wire conv_start,
   input wire [4:0] channel_select,
   input wire irq
);
   reg [7:0] cfg;
   reg cont;
   reg busy;
   reg [1:0] fmt_done;
   wire wr_sc = ce && reg_wr && reg_addr == 8'h40;
   wire mask_wr = ce && reg_wr && reg_addr == 8'h45;
   wire [4:0] wchan = reg_wdata[4:0];
   wire dn = ce && conv_done && busy && !reg_wr;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of software settings; format latched per result, since held data keeps its old format
   always @(posedge clk_sys) begin
      if (rst) begin
         cfg <= 8'h04;
         cont <= 1'b0;
         busy <= 1'b0;
         fmt_done <= 2'h1;
      end else if (ce) begin
         if (reg_wr && reg_addr == 8'h43) cfg <= reg_wdata;
         if (wr_sc) cont <= reg_wdata[5];
         if (conv_done && busy) fmt_done <= cfg[3:2];
         if (conv_start) busy <= 1'b1;
         else if (conv_done || (wr_sc && wchan == 5'h1f)) busy <= 1'b0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   AST_START: assert property (wr_sc && wchan != 5'h1f |=> conv_start)
      else $error("no start after control write");
   AST_CHAN: assert property (wr_sc |=> channel_select == $past(wchan))
      else $error("channel not taken from control write");
   AST_CONT: assert property (dn && cont |=> conv_start)
      else $error("continuous mode did not restart");
   AST_ONE: assert property (dn && !cont |=> !conv_start)
      else $error("single mode restarted");
   AST_IRQ_CLR: assert property (ce && reg_rd && reg_addr == 8'h44 && !conv_done |=> !irq)
      else $error("interrupt survived status read");
   // A mask write reaches the line one cycle after the mask itself changes
   AST_IRQ_SET: assert property ($rose(irq) |-> $past(conv_done) || $past(mask_wr, 2))
      else $error("interrupt rose without cause");
   AST_CFG: assert property (ce && reg_rd && reg_addr == 8'h43 |=> reg_rdata == {cfg[7:2], 2'b00})
      else $error("clock config readback wrong");
   AST_HIGH_RIGHT: assert property (
      ce && reg_rd && reg_addr == 8'h41 && cfg[3:2] == 2'h1 && fmt_done == 2'h1 |=> reg_rdata[7:2] == 6'h00)
      else $error("right format high has upper bits");
   AST_LOW_LEFT: assert property (
      ce && reg_rd && reg_addr == 8'h42 && cfg[3] && fmt_done[1] |=> reg_rdata[5:0] == 6'h00)
      else $error("left format low has lower bits");
endmodule // arc_chk

bind arc_top arc_chk u_chk (.*);

// file: dv/tb.sv
// Self-checking bench for the converter result and clock block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
   reg clk_sys, rst, ce, reg_wr, reg_rd, conv_done;
   reg [7:0] reg_addr, reg_wdata;
   reg [9:0] conv_data;
   reg [1:0] xdiv = 2'h0;
   wire [7:0] reg_rdata;
   wire conv_start, conv_clk_tick, irq;
   wire [4:0] channel_select;
   integer errors, num_checks;
   logic [7:0] exp_hi [4] = '{8'h00, 8'h02, 8'hb5, 8'h35};
   logic [7:0] exp_lo [4] = '{8'hb5, 8'hd5, 8'h40, 8'h40};
   arc_top u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crystal_clock(xdiv[1]),
      .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
      .conv_clk_tick(conv_clk_tick), .channel_select(channel_select), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock; crystal stand-in at a quarter of the bus rate, far above the 1 MHz floor
   initial begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) xdiv <= xdiv + 2'h1;
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One-cycle bus strobes
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e);
   endtask
   // Wait for a start, bounded, then finish the conversion with d
   task conv(input [9:0] d);
      int i;
      for (i = 0; i < 20; i++) begin
         #1;
         if (conv_start === 1'b1) break;
         @(posedge clk_sys);
      end
      if (i == 20) begin
         errors++;
         $display("unexpected at %0t: no start", $time);
         wrap_up;
      end
      @(posedge clk_sys);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge clk_sys);
      conv_done <= 1'b0;
   endtask
   // Count ticks over 64 cycles once the divider has settled
   task presc(input [2:0] r, input s, input [7:0] e);
      logic [7:0] n;
      wr(8'h43, {r, s, 4'h4});
      repeat (40) @(posedge clk_sys);
      n = 0;
      repeat (64) begin
         @(posedge clk_sys);
         #1;
         n = n + conv_clk_tick;
      end
      `CHK(n, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(8'h43, 8'h04);
      rd(8'h40, 8'h1f);
      rd(8'h45, 8'h01);
      rd(8'h7f, 8'h00);
      $display("reset values done");
   endtask
   task t_formats;
      for (int f = 0; f < 4; f++) begin
         wr(8'h43, {4'h1, f[1:0], 2'b00});
         wr(8'h40, 8'h03);
         conv(10'h2d5);
         rd(8'h40, 8'h83);
         rd(8'h41, exp_hi[f]);
         rd(8'h42, exp_lo[f]);
         rd(8'h40, 8'h03);
      end
      $display("formats done");
   endtask
   task t_interlock;
      wr(8'h43, 8'h14);
      wr(8'h40, 8'h03);
      conv(10'h155);
      rd(8'h41, 8'h01);
      wr(8'h40, 8'h03);
      conv(10'h2aa);
      rd(8'h42, 8'h55);
      rd(8'h44, 8'h02);
      wr(8'h43, 8'h10);
      wr(8'h40, 8'h03);
      conv(10'h155);
      rd(8'h41, 8'h00);
      wr(8'h40, 8'h03);
      conv(10'h2aa);
      rd(8'h42, 8'haa);
      $display("interlock done");
   endtask
   task t_irq;
      wr(8'h40, 8'h43);
      conv(10'h155);
      #1 `CHK(irq, 1'b1);
      rd(8'h40, 8'h43);
      rd(8'h42, 8'h55);
      `CHK(irq, 1'b0);
      wr(8'h45, 8'h00);
      wr(8'h40, 8'h43);
      conv(10'h155);
      #1 `CHK(irq, 1'b0);
      wr(8'h45, 8'h01);
      @(posedge clk_sys);
      #1 `CHK(irq, 1'b1);
      wr(8'h40, 8'h5f);
      @(posedge clk_sys);
      #1 `CHK(irq, 1'b0);
      rd(8'h44, 8'h00);
      $display("interrupt done");
   endtask
   task t_cont;
      wr(8'h43, 8'h14);
      wr(8'h40, 8'h23);
      conv(10'h3ff);
      conv(10'h001);
      conv(10'h0aa);
      wr(8'h40, 8'h1f);
      repeat (4) begin
         @(posedge clk_sys);
         #1 `CHK(conv_start, 1'b0);
      end
      rd(8'h41, 8'h00);
      rd(8'h42, 8'haa);
      $display("continuous done");
   endtask
   task t_clock;
      presc(3'h0, 1'b1, 8'd64);
      presc(3'h1, 1'b1, 8'd32);
      presc(3'h2, 1'b1, 8'd16);
      presc(3'h3, 1'b1, 8'd8);
      presc(3'h4, 1'b1, 8'd4);
      presc(3'h7, 1'b1, 8'd4);
      presc(3'h0, 1'b0, 8'd16);
      presc(3'h1, 1'b0, 8'd8);
      presc(3'h5, 1'b0, 8'd1);
      $display("prescaler done");
   endtask
   // A write while the enable is low must leave the clock config as it was
   task t_freeze;
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(8'h43, 8'h14);
      ce <= 1'b1;
      rd(8'h43, 8'ha4);
      $display("freeze done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      errors = 0;
      num_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      conv_done = 1'b0;
      conv_data = 10'h000;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_formats;
      t_interlock;
      t_irq;
      t_cont;
      t_clock;
      t_freeze;
      wrap_up;
   end
endmodule // tb

// file: hdl/arc_prescaler.v
// Power-of-two prescaler that makes the converter clock tick
`timescale 1ns/1ps
`include "arc_regs.vh"

module arc_prescaler (
   // Clock, reset, enable
   input wire clk_sys,
   input wire rst,
   input wire ce,
   // Source ticks and ratio
   input wire src_tick,
   input wire [2:0] ratio,
   // Divided tick
   output reg div_tick
);

   reg [3:0] count;

   // Terminal count for the ratio; top bit set forces divide by 16
   function [3:0] term_count;
      input [2:0] r;
      begin
         if (r[`ARC_RATIO_DIV16_BIT]) begin
            term_count = 4'hf;
         end else begin
            term_count = (4'h1 << r[1:0]) - 4'h1;
         end
      end
   endfunction

   // Count source ticks; a ratio decrease mid-count just ends the count early
   always @(posedge clk_sys) begin
      if (rst) begin
         count <= 4'h0;
         div_tick <= 1'b0;
      end else if (ce) begin
         div_tick <= 1'b0;
         if (src_tick) begin
            if (count >= term_count(ratio)) begin
               count <= 4'h0;
               div_tick <= 1'b1;
            end else begin
               count <= count + 4'h1;
            end
         end
      end
   end

endmodule // arc_prescaler

// file: hdl/arc_regs.vh
// Register offsets, field positions and reset values of the converter result and clock block
`ifndef ARC_REGS_VH
`define ARC_REGS_VH

// Register offsets
`define ARC_ADDR_STATUS_CONTROL 8'h40
`define ARC_ADDR_RESULT_HIGH 8'h41
`define ARC_ADDR_RESULT_LOW 8'h42
`define ARC_ADDR_CLOCK_CONFIG 8'h43
`define ARC_ADDR_IRQ_STATUS 8'h44
`define ARC_ADDR_IRQ_MASK 8'h45

// Status and control fields
`define ARC_SC_DONE_BIT 7
`define ARC_SC_IRQ_EN_BIT 6
`define ARC_SC_CONT_BIT 5
`define ARC_SC_CHAN_MSB 4
`define ARC_SC_CHAN_LSB 0
`define ARC_SC_RESET 8'h1f
`define ARC_CHAN_POWER_OFF 5'h1f

// Clock configuration fields
`define ARC_CLK_RATIO_MSB 7
`define ARC_CLK_RATIO_LSB 5
`define ARC_CLK_SRC_BIT 4
`define ARC_CLK_FMT_MSB 3
`define ARC_CLK_FMT_LSB 2
`define ARC_CLK_RESET 8'h04

// Result format codes
`define ARC_FMT_TRUNC8 2'h0
`define ARC_FMT_RIGHT 2'h1
`define ARC_FMT_LEFT 2'h2
`define ARC_FMT_LEFT_SIGNED 2'h3

// Interrupt status bits and mask reset
`define ARC_IRQ_DONE_BIT 0
`define ARC_IRQ_LOST_BIT 1
`define ARC_IRQ_MASK_RESET 8'h01

// Prescaler ratio codes
`define ARC_RATIO_DIV16_BIT 2

`endif

// file: hdl/arc_top.v
// Result formatting, read interlock, conversion control and converter clock for a 10-bit converter
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "arc_regs.vh"

// Notes on behaviour
// - Left-aligned format puts result bits 9..2 in the high register and bits 1..0 on top of the low register.
// - Right-aligned format puts result bits 9..8 at the bottom of the high register and bits 7..0 in the low.
// - In justified formats a high read freezes the low register until it is read, dropping results meanwhile.
// - Each finished conversion reloads the result registers unless the read interlock holds them.
// - Truncation format loads result bits 9..2 into the low register with no interlock at all.
// - The 3-bit prescale ratio divides by 1, 2, 4, 8, or by 16 whenever its top bit is set.
// - The source select takes the bus clock when 1 and the crystal clock when 0, crystal after reset.
// - The two-bit format field picks truncation, right, left or left signed for codes 0 to 3.
// - Reset returns the format field to right-aligned.
// - With the interrupt off, the done flag sets at each conversion end and stays until a result read.
// - With the interrupt on, conversion end raises it and a result read or control write drops it.
// - Any write of the status and control register aborts the running conversion and starts anew, except with the power-off channel code.
// - Continuous mode converts again after each end; otherwise exactly one conversion runs.
module arc_top (
   // Clock, reset, enable
   input wire clk_sys,
   input wire rst,
   input wire ce,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Crystal clock pin, sampled as a level
   input wire crystal_clock,
   // Converter core
   input wire conv_done,
   input wire [9:0] conv_data,
   output reg conv_start,
   output reg conv_clk_tick,
   output reg [4:0] channel_select,
   // Interrupt
   output reg irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset images of the writable registers; fields are sliced out below
   localparam [7:0] CLK_RESET = `ARC_CLK_RESET;
   localparam [7:0] SC_RESET = `ARC_SC_RESET;
   localparam [7:0] MASK_RESET = `ARC_IRQ_MASK_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // State: software-visible control fields
   reg conversion_irq_enable;
   reg continuous_convert;
   reg conversion_done_flag;
   reg [2:0] prescale_ratio;
   reg prescale_source_sel;
   reg [1:0] result_format_sel;
   // Result path and interlock
   reg [7:0] result_high;
   reg [7:0] result_low;
   reg low_hold;
   reg busy;
   // Interrupt events and crystal synchroniser
   reg [1:0] irq_status;
   reg [1:0] irq_mask;
   reg xtal_meta;
   reg xtal_sync;
   reg xtal_last;

   // Derived strobes, ticks and the formatted result
   wire div_tick;
   wire src_tick;
   wire end_of_conv;
   wire wr_sc;
   wire wr_clk;
   wire wr_mask;
   wire rd_high;
   wire rd_low;
   wire rd_irq;
   wire result_read;
   wire justified;
   wire [15:0] formatted;
   wire [1:0] next_irq_status;
   wire [7:0] sc_view;
   reg [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded strobes
   // Strobes are qualified by address only; ce gates them inside each process
   assign wr_sc = reg_wr && (reg_addr == `ARC_ADDR_STATUS_CONTROL);
   assign wr_clk = reg_wr && (reg_addr == `ARC_ADDR_CLOCK_CONFIG);
   assign wr_mask = reg_wr && (reg_addr == `ARC_ADDR_IRQ_MASK);
   assign rd_high = reg_rd && (reg_addr == `ARC_ADDR_RESULT_HIGH);
   assign rd_low = reg_rd && (reg_addr == `ARC_ADDR_RESULT_LOW);
   assign rd_irq = reg_rd && (reg_addr == `ARC_ADDR_IRQ_STATUS);
   assign result_read = rd_high || rd_low;

   // A done pulse only counts while a conversion is ours to finish
   assign end_of_conv = conv_done && busy;
   assign justified = (result_format_sel != `ARC_FMT_TRUNC8);

   ////////////////////////////////////////////////////////////////////////////
   // Result placement: high byte on top, low byte below
   function [15:0] place_result;
      input [1:0] fmt;
      input [9:0] d;
      begin
         case (fmt)
            `ARC_FMT_TRUNC8: begin
               place_result = {8'h00, d[9:2]};
            end
            `ARC_FMT_RIGHT: begin
               place_result = {6'h00, d[9:8], d[7:0]};
            end
            `ARC_FMT_LEFT: begin
               place_result = {d[9:2], d[1:0], 6'h00};
            end
            default: begin
               place_result = {~d[9], d[8:2], d[1:0], 6'h00};
            end
         endcase
      end
   endfunction

   assign formatted = place_result(result_format_sel, conv_data);

   ////////////////////////////////////////////////////////////////////////////
   // Crystal clock synchroniser; edges taken only past the second stage
   // The first stage may go metastable, so nothing but the second stage reads it
   always @(posedge clk_sys) begin
      if (rst) begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
         xtal_last <= 1'b0;
      end else if (ce) begin
         xtal_meta <= crystal_clock;
         xtal_sync <= xtal_meta;
         xtal_last <= xtal_sync;
      end
   end

   // Crystal must be well under half the bus rate to be seen edge by edge
   assign src_tick = prescale_source_sel ? 1'b1 : (xtal_sync && !xtal_last);

   // Divider kept apart so a longer ratio field only touches that module
   arc_prescaler u_prescaler (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .src_tick(src_tick),
      .ratio(prescale_ratio),
      .div_tick(div_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock configuration and status/control fields
   always @(posedge clk_sys) begin
      if (rst) begin
         // Each field takes exactly its own slice of the reset image
         prescale_ratio <= CLK_RESET[`ARC_CLK_RATIO_MSB:`ARC_CLK_RATIO_LSB];
         prescale_source_sel <= CLK_RESET[`ARC_CLK_SRC_BIT];
         result_format_sel <= CLK_RESET[`ARC_CLK_FMT_MSB:`ARC_CLK_FMT_LSB];
         conversion_irq_enable <= SC_RESET[`ARC_SC_IRQ_EN_BIT];
         continuous_convert <= SC_RESET[`ARC_SC_CONT_BIT];
         channel_select <= SC_RESET[`ARC_SC_CHAN_MSB:`ARC_SC_CHAN_LSB];
         irq_mask <= MASK_RESET[1:0];
      end else if (ce) begin
         if (wr_clk) begin
            prescale_ratio <= reg_wdata[`ARC_CLK_RATIO_MSB:`ARC_CLK_RATIO_LSB];
            prescale_source_sel <= reg_wdata[`ARC_CLK_SRC_BIT];
            result_format_sel <= reg_wdata[`ARC_CLK_FMT_MSB:`ARC_CLK_FMT_LSB];
         end
         // The done bit is read only; its written value is ignored
         if (wr_sc) begin
            conversion_irq_enable <= reg_wdata[`ARC_SC_IRQ_EN_BIT];
            continuous_convert <= reg_wdata[`ARC_SC_CONT_BIT];
            channel_select <= reg_wdata[`ARC_SC_CHAN_MSB:`ARC_SC_CHAN_LSB];
         end
         if (wr_mask) begin
            irq_mask <= reg_wdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencing: a control write restarts, continuous re-arms
   // A control write outranks a done pulse in the same cycle for the restart; that result still loads
   always @(posedge clk_sys) begin
      if (rst) begin
         busy <= 1'b0;
         conv_start <= 1'b0;
      end else if (ce) begin
         conv_start <= 1'b0;
         if (wr_sc) begin
            // Power-off channel code leaves the core idle
            if (reg_wdata[`ARC_SC_CHAN_MSB:`ARC_SC_CHAN_LSB] != `ARC_CHAN_POWER_OFF) begin
               busy <= 1'b1;
               conv_start <= 1'b1;
            end else begin
               busy <= 1'b0;
            end
         end else if (end_of_conv) begin
            if (continuous_convert) begin
               conv_start <= 1'b1;
            end else begin
               busy <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result registers and the high/low read interlock
   // Both halves are held; a high byte pairs with a newer low byte only when a result loads in the cycle of the high read
   // Limitation: a high read never followed by a low read stalls all updates
   always @(posedge clk_sys) begin
      if (rst) begin
         result_high <= 8'h00;
         result_low <= 8'h00;
         low_hold <= 1'b0;
      end else if (ce) begin
         if (end_of_conv && !low_hold) begin
            result_high <= formatted[15:8];
            result_low <= formatted[7:0];
         end
         // Low read releases; a high read in the same justified mode grabs
         if (rd_high && justified) begin
            low_hold <= 1'b1;
         end else if (rd_low || !justified) begin
            low_hold <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Done flag: polled mode only; set wins over a same-cycle read
   // Interrupt mode keeps the flag at zero; software then follows the line
   always @(posedge clk_sys) begin
      if (rst) begin
         conversion_done_flag <= 1'b0;
      end else if (ce) begin
         if (end_of_conv && !conversion_irq_enable) begin
            conversion_done_flag <= 1'b1;
         end else if (result_read || conversion_irq_enable) begin
            conversion_done_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events: done (interrupt mode) and a result lost to the interlock
   assign next_irq_status[`ARC_IRQ_DONE_BIT] =
      (end_of_conv && conversion_irq_enable) ||
      (irq_status[`ARC_IRQ_DONE_BIT] && !rd_irq && !result_read && !wr_sc);
   assign next_irq_status[`ARC_IRQ_LOST_BIT] =
      (end_of_conv && low_hold) || (irq_status[`ARC_IRQ_LOST_BIT] && !rd_irq);

   // Line follows the next status so it rises in the same cycle as the sticky bit
   always @(posedge clk_sys) begin
      if (rst) begin
         irq_status <= 2'h0;
         irq <= 1'b0;
      end else if (ce) begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe; unmapped reads give zero
   assign sc_view = {conversion_done_flag, conversion_irq_enable, continuous_convert, channel_select};

   // Reads have no side effect in this mux; the clearing strobes are decoded above
   always @* begin
      next_rdata = 8'h00;
      if (reg_addr == `ARC_ADDR_STATUS_CONTROL) begin
         next_rdata = sc_view;
      end else if (reg_addr == `ARC_ADDR_RESULT_HIGH) begin
         next_rdata = result_high;
      end else if (reg_addr == `ARC_ADDR_RESULT_LOW) begin
         next_rdata = result_low;
      end else if (reg_addr == `ARC_ADDR_CLOCK_CONFIG) begin
         next_rdata = {prescale_ratio, prescale_source_sel, result_format_sel, 2'h0};
      end else if (reg_addr == `ARC_ADDR_IRQ_STATUS) begin
         next_rdata = {6'h00, irq_status};
      end else if (reg_addr == `ARC_ADDR_IRQ_MASK) begin
         next_rdata = {6'h00, irq_mask};
      end
   end

   // Read data stands one cycle only; the converter tick is retimed to a flop
   always @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         conv_clk_tick <= 1'b0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
         conv_clk_tick <= div_tick;
      end
   end

endmodule // arc_top
